/* File: hw/fir_coeff_bank_a.sv */
// channel-a coefficient bank with its nine-tap equaliser datapath
// Behaviour
// - side coefficients: signed, low twelve bits
// - centre coefficient: signed eighteen bits, rest reserved
// - nine taps, fifth is centre
// - dual mode: bank feeds channel a only
// - merged mode: bank feeds combined stream
// - taps ascend with address, centre 0x420
// - mode 0 bypasses, mode 2 filters
// - side lsb weight two to scw-16
`default_nettype none
module fir_coeff_bank_a (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [fir_bank_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fir_bank_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [fir_bank_pkg::DATA_W-1:0] reg_rdata,
    input wire logic serial_link_enable,
    input wire logic [fir_bank_pkg::SAMPLE_W-1:0] sample_in,
    input wire logic sample_chan_b,
    input wire logic sample_valid,
    output logic sample_ready,
    output logic [fir_bank_pkg::OUT_W-1:0] filt_data,
    output logic filt_valid,
    input wire logic filt_ready
);
    import fir_bank_pkg::*;

    ////////////////////////////////////////////////////////////////
    // all state of the bank except the output buffer, which lives in u_skid
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] scw;
        logic merge;
        logic [TAPS-1:0][CENTRE_W-1:0] coeff;
        logic [TAPS-1:0][SAMPLE_W-1:0] line;
        logic [DATA_W-1:0] rdata;
    } bank_type;

    bank_type s_q, s_d;

    logic take;
    logic use_samp;
    logic push_ready;
    logic [OUT_W-1:0] push_data;
    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] cs;
    logic signed [ACC_W-1:0] xs;
    logic signed [ACC_W-1:0] term;
    logic signed [ACC_W-1:0] scaled;

    ////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        s_d = s_q;
        acc = '0;
        cs = '0;
        xs = '0;
        term = '0;
        scaled = '0;
        push_data = '0;

        // chan b words are drained but kept out of the line unless merged
        take = sample_valid && push_ready;
        use_samp = take && (s_q.merge || !sample_chan_b);

        // newest sample at index 0, oldest drops off the end
        if (use_samp) begin
            s_d.line = {s_q.line[TAPS-2:0], sample_in};
        end

        // weighted sum over the freshly shifted line
        for (int k = 0; k < TAPS; k++) begin
            xs = ACC_W'($signed(s_d.line[k]));
            if (k == CENTRE_TAP) begin
                // centre keeps its fixed weight of two to minus sixteen
                cs = ACC_W'($signed(s_q.coeff[k]));
                term = cs * xs;
            end else begin
                // side weight is a left shift by the weight field
                cs = ACC_W'($signed(s_q.coeff[k][SIDE_W-1:0]));
                term = (cs * xs) <<< s_q.scw;
            end
            acc = acc + term;
        end

        // drop the fraction and clip instead of wrapping
        scaled = acc >>> FRAC_BITS;
        if (s_q.mode == MODE_ENABLE) begin
            if (scaled > OUT_MAX) begin
                push_data = OUT_W'(OUT_MAX);
            end else if (scaled < OUT_MIN) begin
                push_data = OUT_W'(OUT_MIN);
            end else begin
                push_data = OUT_W'(scaled);
            end
        end else begin
            // reserved modes behave as bypass rather than garbage
            push_data = OUT_W'($signed(sample_in));
        end

        // register writes; the host keeps them to link-idle periods
        if (reg_wr) begin
            if (reg_addr == CFG_ADDR) begin
                s_d.mode = reg_wdata[MODE_LSB +: 2];
                s_d.merge = reg_wdata[MERGE_BIT];
                // weights above six are clipped to the top legal step
                if (reg_wdata[SCW_LSB +: 3] > SCW_MAX) begin
                    s_d.scw = SCW_MAX;
                end else begin
                    s_d.scw = reg_wdata[SCW_LSB +: 3];
                end
            end
            for (int k = 0; k < TAPS; k++) begin
                if (reg_addr == TAP_ADDR[k]) begin
                    if (k == CENTRE_TAP) begin
                        s_d.coeff[k] = reg_wdata[CENTRE_W-1:0];
                    end else begin
                        s_d.coeff[k] = CENTRE_W'(reg_wdata[SIDE_W-1:0]);
                    end
                end
            end
        end

        // read data stand for one cycle only, zero otherwise
        s_d.rdata = '0;
        if (reg_rd) begin
            if (reg_addr == CFG_ADDR) begin
                s_d.rdata[MODE_LSB +: 2] = s_q.mode;
                s_d.rdata[SCW_LSB +: 3] = s_q.scw;
                s_d.rdata[MERGE_BIT] = s_q.merge;
            end
            if (reg_addr == STATUS_ADDR) begin
                s_d.rdata[ST_ACTIVE] = (s_q.mode == MODE_ENABLE);
                s_d.rdata[ST_MERGED] = s_q.merge;
                s_d.rdata[ST_LINK] = serial_link_enable;
                s_d.rdata[ST_OUT_VALID] = filt_valid;
                s_d.rdata[ST_IN_READY] = push_ready;
            end
            // reserved bits above each field read as zero
            for (int k = 0; k < TAPS; k++) begin
                if (reg_addr == TAP_ADDR[k]) begin
                    s_d.rdata = DATA_W'(s_q.coeff[k]);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q.mode <= MODE_RST;
            s_q.scw <= SCW_RST;
            s_q.merge <= MERGE_RST;
            s_q.coeff <= {TAPS{COEFF_RST}};
            s_q.line <= '0;
            s_q.rdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // output buffer; its ready stalls the sample source
    fir_out_skid #(
        .WIDTH(OUT_W)
    ) u_skid (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .push_valid(use_samp),
        .push_data(push_data),
        .push_ready(push_ready),
        .pop_valid(filt_valid),
        .pop_data(filt_data),
        .pop_ready(filt_ready)
    );

    assign sample_ready = push_ready;
    assign reg_rdata = s_q.rdata;

    ////////////////////////////////////////////////////////////////
    // helpers for the checks below
    logic [SIDE_W-1:0] w_side;
    logic [CENTRE_W-1:0] w_centre;
    logic [2:0] w_scw;
    logic [SAMPLE_W-1:0] mid_tap;
    logic [CENTRE_W-1:0] tap6_coeff;
    logic [CENTRE_W-1:0] centre_coeff;
    logic [1:0] w_mode;
    logic [OUT_W-1:0] byp_data;

    assign centre_coeff = s_q.coeff[CENTRE_TAP];
    assign w_mode = reg_wdata[MODE_LSB +: 2];
    assign byp_data = OUT_W'($signed(sample_in));
    assign w_side = reg_wdata[SIDE_W-1:0];
    assign w_centre = reg_wdata[CENTRE_W-1:0];
    assign w_scw = reg_wdata[SCW_LSB +: 3];
    assign mid_tap = s_q.line[TAPS-2];
    assign tap6_coeff = s_q.coeff[6];

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // side write keeps twelve bits, upper bits forced clear
    a_side_store: assert property (
        reg_wr && reg_addr == TAP_ADDR[0]
        |=> s_q.coeff[0] == CENTRE_W'($past(w_side)))
        else $error("side tap did not keep low twelve bits");

    // reserved bits of a side tap read back as zero
    a_side_resv: assert property (
        reg_rd && reg_addr == TAP_ADDR[1]
        |=> reg_rdata[DATA_W-1:SIDE_W] == '0)
        else $error("side tap reserved bits not zero");

    // centre write keeps all eighteen bits, read shows them
    a_centre_full: assert property (
        reg_wr && reg_addr == TAP_ADDR[CENTRE_TAP] ##1 !reg_wr
        ##1 reg_rd && reg_addr == TAP_ADDR[CENTRE_TAP] && !reg_wr
        |=> reg_rdata == DATA_W'($past(w_centre, 3)))
        else $error("centre tap readback wrong");

    // centre write lands whole in the centre tap
    a_centre_store: assert property (
        reg_wr && reg_addr == TAP_ADDR[CENTRE_TAP]
        |=> s_q.coeff[CENTRE_TAP] == $past(w_centre))
        else $error("centre tap did not keep eighteen bits");

    // bits above the centre coefficient read as zero
    a_centre_resv: assert property (
        reg_rd && reg_addr == TAP_ADDR[CENTRE_TAP]
        |=> reg_rdata[DATA_W-1:CENTRE_W] == '0)
        else $error("centre tap reserved bits not zero");

    // an accepted sample walks one place down the nine-deep line
    a_line_shift: assert property (
        use_samp |=> s_q.line[TAPS-1] == $past(mid_tap))
        else $error("delay line did not shift");

    // no accepted sample, no movement in the line
    a_line_hold: assert property (
        !use_samp
        |=> $stable(s_q.line))
        else $error("delay line moved without a sample");

    // dual mode leaves the line alone for second-channel words
    a_dual_drop: assert property (
        take && sample_chan_b && !s_q.merge |=> $stable(s_q.line))
        else $error("second channel entered dual-mode line");

    // a dropped second-channel word produces no output word
    a_dual_no_out: assert property (
        take && sample_chan_b && !s_q.merge && !filt_valid
        |=> !filt_valid)
        else $error("second channel word reached dual-mode output");

    // merged mode takes second-channel words as its own
    a_merge_take: assert property (
        take && sample_chan_b && s_q.merge
        |=> s_q.line[0] == $past(sample_in))
        else $error("merged stream lost a sample");

    // merge control follows its configuration bit
    a_merge_store: assert property (
        reg_wr && reg_addr == CFG_ADDR
        |=> s_q.merge == $past(reg_wdata[MERGE_BIT]))
        else $error("merge control not stored");

    // third tap sits at 0x41C, seventh read from 0x425
    a_tap_map: assert property (
        reg_wr && reg_addr == 12'h41C
        |=> s_q.coeff[2] == CENTRE_W'($past(w_side)))
        else $error("0x41C did not reach the third tap");

    a_tap_read: assert property (
        reg_rd && reg_addr == 12'h425
        |=> reg_rdata == DATA_W'($past(tap6_coeff)))
        else $error("0x425 did not read the seventh tap");

    // the centre tap answers at 0x420
    a_centre_read: assert property (
        reg_rd && reg_addr == 12'h420
        |=> reg_rdata == DATA_W'($past(centre_coeff)))
        else $error("0x420 did not read the centre tap");

    // read data stand only in the cycle after a read strobe
    a_rdata_idle: assert property (
        !reg_rd
        |=> reg_rdata == '0)
        else $error("read data outside the read cycle");

    // bypass passes the sample straight into the buffer
    a_bypass_pass: assert property (
        use_samp && s_q.mode == MODE_BYPASS
        |-> push_data == OUT_W'($signed(sample_in)))
        else $error("bypass altered the sample");

    // reserved modes reach the output as plain bypass words
    a_resv_bypass: assert property (
        use_samp && s_q.mode != MODE_ENABLE && !filt_valid
        |=> filt_data == $past(byp_data))
        else $error("non-filter mode altered the output word");

    // mode field follows its configuration bits
    a_mode_store: assert property (
        reg_wr && reg_addr == CFG_ADDR
        |=> s_q.mode == $past(w_mode))
        else $error("mode field not stored");

    // status reports the filter as active only in mode two
    a_status_on: assert property (
        reg_rd && reg_addr == STATUS_ADDR
        |=> reg_rdata[ST_ACTIVE] == $past(s_q.mode == MODE_ENABLE))
        else $error("status active bit wrong");

    // weight field never rises above six
    a_scw_clip: assert property (
        reg_wr && reg_addr == CFG_ADDR && w_scw > SCW_MAX
        |=> s_q.scw == SCW_MAX)
        else $error("side weight above six stored");

    // legal weights are kept exactly as written
    a_scw_store: assert property (
        reg_wr && reg_addr == CFG_ADDR && w_scw <= SCW_MAX
        |=> s_q.scw == $past(w_scw))
        else $error("legal side weight not stored");

    // every used sample yields one output word next cycle
    a_out_valid: assert property (
        use_samp
        |=> filt_valid)
        else $error("accepted sample gave no output word");

    // into an empty buffer the computed word appears at once
    a_out_first: assert property (
        use_samp && !filt_valid
        |=> filt_data == $past(push_data))
        else $error("output word differs from the computed sum");
endmodule // fir_coeff_bank_a
`default_nettype wire

/* File: hw/fir_bank_pkg.sv */
// constants shared by the channel-a equaliser coefficient bank
`default_nettype none
package fir_bank_pkg;
    // bus and datapath widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 24;
    localparam int SAMPLE_W = 12;
    localparam int OUT_W = 16;
    localparam int SIDE_W = 12;
    localparam int CENTRE_W = 18;
    localparam int ACC_W = 40;
    localparam int FRAC_BITS = 16;
    // tap layout
    localparam int TAPS = 9;
    localparam int CENTRE_TAP = 4;
    // register offsets, taps in ascending address order
    localparam logic [ADDR_W-1:0] CFG_ADDR = 12'h400;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h401;
    localparam logic [ADDR_W-1:0] TAP_ADDR [TAPS] = '{
        12'h418, 12'h41A, 12'h41C, 12'h41E, 12'h420,
        12'h423, 12'h425, 12'h427, 12'h429};
    // configuration fields
    localparam int MODE_LSB = 0;
    localparam int SCW_LSB = 2;
    localparam int MERGE_BIT = 5;
    localparam logic [1:0] MODE_BYPASS = 2'h0;
    localparam logic [1:0] MODE_ENABLE = 2'h2;
    localparam logic [2:0] SCW_MAX = 3'h6;
    // reset values
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [2:0] SCW_RST = 3'h0;
    localparam logic MERGE_RST = 1'h0;
    localparam logic [CENTRE_W-1:0] COEFF_RST = 18'h0;
    // status fields
    localparam int ST_ACTIVE = 0;
    localparam int ST_MERGED = 1;
    localparam int ST_LINK = 2;
    localparam int ST_OUT_VALID = 3;
    localparam int ST_IN_READY = 4;
    // output saturation limits
    localparam logic signed [ACC_W-1:0] OUT_MAX = 40'sh0000007FFF;
    localparam logic signed [ACC_W-1:0] OUT_MIN = -40'sh0000008000;
endpackage
`default_nettype wire

/* File: hw/fir_out_skid.sv */
// two-entry output buffer between the filter and the receiver
`default_nettype none
module fir_out_skid #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic push_valid,
    input wire logic [WIDTH-1:0] push_data,
    output logic push_ready,
    output logic pop_valid,
    output logic [WIDTH-1:0] pop_data,
    input wire logic pop_ready
);
    typedef struct packed {
        logic [WIDTH-1:0] head;
        logic [WIDTH-1:0] tail;
        logic head_v;
        logic tail_v;
        logic room;
    } skid_type;

    skid_type s_q, s_d;

    ////////////////////////////////////////////////////////////////
    // pop shifts the tail forward, then a push fills the first hole
    always_comb begin
        s_d = s_q;
        if (s_q.head_v && pop_ready) begin
            s_d.head = s_q.tail;
            s_d.head_v = s_q.tail_v;
            s_d.tail_v = 1'b0;
        end
        // ready is a flop, so a push never meets a full buffer
        if (push_valid && !s_q.tail_v) begin
            if (!s_d.head_v) begin
                s_d.head = push_data;
                s_d.head_v = 1'b1;
            end else begin
                s_d.tail = push_data;
                s_d.tail_v = 1'b1;
            end
        end
        // ready registered so the top output comes straight from a flop
        s_d.room = !s_d.tail_v;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{head: '0, tail: '0, head_v: 1'b0, tail_v: 1'b0, room: 1'b1};
        end else begin
            s_q <= s_d;
        end
    end

    assign push_ready = s_q.room;
    assign pop_valid = s_q.head_v;
    assign pop_data = s_q.head;
endmodule // fir_out_skid
`default_nettype wire

/* File: test/tb_fir_coeff_bank_a.sv */
// self-checking bench for the channel-a equaliser coefficient bank
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end
module tb_fir_coeff_bank_a;
    timeunit 1ns;
    timeprecision 1ps;
    import fir_bank_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic serial_link_enable = 1'b0;
    logic [SAMPLE_W-1:0] sample_in = '0;
    logic sample_chan_b = 1'b0;
    logic sample_valid = 1'b0;
    logic sample_ready;
    logic [OUT_W-1:0] filt_data;
    logic filt_valid;
    logic filt_ready = 1'b0;
    int errors = 0;
    int checks = 0;
    fir_coeff_bank_a dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_link_enable(serial_link_enable), .sample_in(sample_in),
        .sample_chan_b(sample_chan_b), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .filt_data(filt_data), .filt_valid(filt_valid),
        .filt_ready(filt_ready));
    ////////////////////////////////////////////////////////////////////////////
    // 40 MHz clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // register bus: one-cycle strobes, read data only in the following cycle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    // sample held until the edge that sees ready, bounded wait
    task automatic push(input logic [SAMPLE_W-1:0] x, input logic b);
        logic ok;
        int n;
        @(posedge sys_clk);
        sample_in <= x;
        sample_chan_b <= b;
        sample_valid <= 1'b1;
        n = 0;
        do begin
            #1 ok = sample_ready;
            @(posedge sys_clk);
            n++;
        end while (ok !== 1'b1 && n < 50);
        sample_valid <= 1'b0;
        `CHK(ok, 1'b1)
    endtask
    task automatic pop(input logic [OUT_W-1:0] e);
        logic ok;
        logic [OUT_W-1:0] d;
        int n;
        @(posedge sys_clk);
        filt_ready <= 1'b1;
        n = 0;
        do begin
            #1 ok = filt_valid;
            d = filt_data;
            @(posedge sys_clk);
            n++;
        end while (ok !== 1'b1 && n < 50);
        filt_ready <= 1'b0;
        `CHK(ok, 1'b1)
        `CHK(d, e)
    endtask
    // tap0 negative with junk in reserved bits, centre exactly one
    function automatic logic [DATA_W-1:0] coeff(input int k);
        return (k == CENTRE_TAP) ? 24'h010000 : (k == 0) ? 24'hFFFFC0 : DATA_W'(64 * (k + 1));
    endfunction
    // impulse 1024 at scw 2: side gives c*4/64, centre gives 1024
    function automatic logic [OUT_W-1:0] resp(input int k);
        return (k == CENTRE_TAP) ? 16'h0400 : (k == 0) ? 16'hFFFC : OUT_W'(4 * (k + 1));
    endfunction
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #(20000 * 25);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        print_verdict();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        // reset values, reserved bits, unmapped and read-only places
        rd(CFG_ADDR, 24'h000000);
        for (int k = 0; k < TAPS; k++) begin
            rd(TAP_ADDR[k], 24'h000000);
            wr(TAP_ADDR[k], 24'hFFFFFF);
            rd(TAP_ADDR[k], (k == CENTRE_TAP) ? 24'h03FFFF : 24'h000FFF);
        end
        wr(12'h4FF, 24'h123456);
        rd(12'h4FF, 24'h000000);
        wr(STATUS_ADDR, 24'hFFFFFF);
        rd(STATUS_ADDR, 24'h000010);
        // weight seven is clipped to six
        wr(CFG_ADDR, 24'h00001C);
        rd(CFG_ADDR, 24'h000018);
        $display("test registers done");
        // bypass for modes 0, 1 and 3: sign-extended sample
        for (int m = 0; m < 4; m = m + 1 + (m == 1)) begin
            wr(CFG_ADDR, DATA_W'(m));
            push(12'h800, 1'b0);
            pop(16'hF800);
        end
        $display("test bypass done");
        // flush in bypass so the bypass samples cannot leak into the impulse
        for (int k = 0; k < TAPS; k++) begin
            push(12'h000, 1'b0);
            pop(16'h0000);
        end
        // impulse response in filter mode walks the taps in address order
        wr(CFG_ADDR, 24'h00000A);
        rd(STATUS_ADDR, 24'h000011);
        for (int k = 0; k < TAPS; k++) wr(TAP_ADDR[k], coeff(k));
        for (int k = 0; k < TAPS; k++) begin
            push((k == 0) ? 12'h400 : 12'h000, 1'b0);
            pop(resp(k));
        end
        $display("test impulse done");
        // dual mode drops second-channel samples, merged mode keeps them
        wr(CFG_ADDR, 24'h000000);
        push(12'h123, 1'b1);
        repeat (3) @(posedge sys_clk);
        #1 `CHK(filt_valid, 1'b0)
        // merge set first; the link runs only once configuration is done
        wr(CFG_ADDR, 24'h000020);
        serial_link_enable <= 1'b1;
        rd(STATUS_ADDR, 24'h000016);
        push(12'h123, 1'b1);
        pop(16'h0123);
        push(12'h7FF, 1'b0);
        pop(16'h07FF);
        serial_link_enable <= 1'b0;
        $display("test channels done");
        // receiver stalls: two words fill the buffer, then nothing is taken
        wr(CFG_ADDR, 24'h000000);
        push(12'h001, 1'b0);
        push(12'h002, 1'b0);
        #1 `CHK(sample_ready, 1'b0)
        rd(STATUS_ADDR, 24'h000008);
        pop(16'h0001);
        pop(16'h0002);
        repeat (2) @(posedge sys_clk);
        #1 `CHK(filt_valid, 1'b0)
        `CHK(sample_ready, 1'b1)
        $display("test buffer done");
        print_verdict();
    end
endmodule // tb_fir_coeff_bank_a
`undef CHK
`default_nettype wire
